// ### logic/gauge_regs.vh
// register map, attribute ids, service codes and fixed values of the gauge slave logic
// assumes a 32-bit avalon-mm slave with byte addresses and word-aligned registers
`ifndef GAUGE_REGS_VH
`define GAUGE_REGS_VH

// ==========================================================
// register byte offsets
`define OFS_CMD 5'h00
`define OFS_CMD_DATA 5'h04
`define OFS_RSP 5'h08
`define OFS_RSP_DATA 5'h0c
`define OFS_SENSE 5'h10
`define OFS_DIAG 5'h14

// ==========================================================
// command word fields
`define CMD_SVC_LSB 0
`define CMD_ATTR_LSB 8
`define CMD_OBJ_LSB 16
`define CMD_TGT_BIT 24

// object selectors
`define OBJ_SENSOR 2'h0
`define OBJ_TRIP_CLASS 2'h1
`define OBJ_TRIP_1 2'h2
`define OBJ_TRIP_2 2'h3

// ==========================================================
// service codes
`define SVC_GET 8'h0e
`define SVC_SET 8'h10
`define SVC_ZERO_ADJ 8'h4b
`define SVC_GAIN_ADJ 8'h4c

// general status codes returned in the response
`define ST_SUCCESS 8'h00
`define ST_SVC_UNSUP 8'h08
`define ST_NOT_SETTABLE 8'h0e
`define ST_ATTR_UNSUP 8'h14

// ==========================================================
// sensor object attributes
`define AT_VALID 8'h05
`define AT_VALUE 8'h06
`define AT_OVERRANGE 8'h20
`define AT_UNDERRANGE 8'h21
`define AT_WARNING 8'h5e
`define AT_ALARM 8'h5f
`define AT_STATUS_EXT 8'h60

// trip point class and instance attributes
`define AT_REVISION 8'h01
`define AT_MAX_INST 8'h02
`define AT_HIGH_LIMIT 8'h03
`define AT_HIGH_EN 8'h04
`define AT_LOW_LIMIT 8'h05
`define AT_LOW_EN 8'h06
`define AT_OUT_STATUS 8'h07
`define AT_HIGH_HYST 8'h12
`define AT_LOW_HYST 8'h13
`define AT_TRIP_STATUS 8'h14

// ==========================================================
// bit positions and fixed values
`define WARN_ELEC_BIT 9
`define ALARM_ELEM_BIT 0
`define ALARM_ELEC_BIT 9
`define EXT_INVALID_BIT 0
`define EXT_OVER_BIT 1
`define EXT_UNDER_BIT 2
`define TRIP_REVISION 16'h0001
`define TRIP_MAX_INST 16'h0002

`endif

// ### logic/gauge_trip.v
// gauge slave logic: sensor status maps, service decode, calibration start, two trip points
// assumes sensor inputs come from logic on i_ref_clk; software issues services over avalon-mm
//
// Operation
// RULE1 - warning word: only byte1 bit1 electronics warning
// RULE2 - alarm word: element failure, electronics failure
// RULE3 - status byte: invalid, overrange, underrange bits
// RULE4 - invalid bit is inverse of reading valid
// RULE5 - service 0e returns addressed attribute
// RULE6 - service 10 overwrites addressed attribute
// RULE7 - service 4c starts gain calibration
// RULE8 - service 4b starts zero calibration
// RULE9 - gain calibration forces value to atmosphere
// RULE10 - zero calibration forces value to zero
// RULE11 - calibration changes no object state
// RULE12 - success answered once calibration begins
// RULE13 - master calibrates without target, in reference condition
// RULE14 - two trip points drive two relays
// RULE15 - class attributes revision and max instance
// RULE16 - high limit trips at or above
// RULE17 - high enable gates high comparison
// RULE18 - low limit trips at or below
// RULE19 - low enable gates low comparison
// RULE20 - output status one while tripped
// RULE21 - low trip clears above limit plus hysteresis
// RULE22 - high trip clears below limit minus hysteresis
// RULE23 - reading invalid beyond over or under range
// RULE24 - disabled comparison never trips; relay ors both
// RULE25 - set on read-only attribute is rejected
`timescale 1ns/1ps
`include "gauge_regs.vh"

module gauge_trip #(
    parameter W = 16,
    parameter signed [15:0] OVERRANGE = 16'sh7fff,
    parameter signed [15:0] UNDERRANGE = -16'sh7fff,
    parameter signed [15:0] GAIN_TARGET = 16'sh3e80,
    parameter signed [15:0] HIGH_DEF = 16'sh7fff,
    parameter signed [15:0] LOW_DEF = 16'sh0000,
    parameter signed [15:0] HYST_DEF = 16'sh0010
) (
    // clock and reset
    input wire i_ref_clk,
    input wire i_arst_n,
    // avalon-mm slave
    input wire [4:0] i_address,
    input wire i_read,
    input wire i_write,
    input wire [31:0] i_writedata,
    output wire [31:0] o_readdata,
    output wire o_waitrequest,
    // sensor side
    input wire i_sample,
    input wire [15:0] i_sensor_value,
    input wire i_elec_warn,
    input wire i_elem_fail,
    input wire i_elec_fail,
    // calibration and relays
    output wire o_gain_cal_start,
    output wire o_zero_cal_start,
    output wire [1:0] o_relay
);

    // ==========================================================
    // avalon handshake: every access waits exactly one cycle
    // the wait state lets read data come from a flop; at most one access per two cycles
    reg ack_reg;
    reg [31:0] rdata_reg;
    wire access = i_read | i_write;
    wire fire = access & ack_reg;
    assign o_waitrequest = access & ~ack_reg;
    assign o_readdata = rdata_reg;

    always @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= access & ~ack_reg;
        end
    end

    // ==========================================================
    // sensor value and status maps
    // the fault inputs are levels from logic on this clock, so they need no synchroniser
    // range limits are build-time constants, so a set to them is refused as read-only
    reg signed [15:0] value_reg;
    reg [31:0] cmd_data_reg;
    wire over = value_reg > OVERRANGE; // RULE23
    wire under = value_reg < UNDERRANGE; // RULE23
    wire valid = ~(over | under);
    wire [15:0] warn_word = {6'h00, i_elec_warn, 9'h000}; // RULE1
    wire [15:0] alarm_word = {6'h00, i_elec_fail, 8'h00, i_elem_fail}; // RULE2
    wire [7:0] status_ext = {5'h00, under, over, ~valid}; // RULE3 RULE4

    // ==========================================================
    // command decode, done in the write cycle of the command word
    // the target flag of the command word is ignored: both adjust targets are fixed
    wire cmd_wr = fire & i_write & (i_address == `OFS_CMD);
    wire [7:0] svc = i_writedata[`CMD_SVC_LSB +: 8];
    wire [7:0] attr = i_writedata[`CMD_ATTR_LSB +: 8];
    wire [1:0] obj = i_writedata[`CMD_OBJ_LSB +: 2];
    wire is_inst = (obj == `OBJ_TRIP_1) | (obj == `OBJ_TRIP_2);
    wire inst_sel = (obj == `OBJ_TRIP_2);

    // per-instance attribute views, flattened
    // flat vectors let the read mux pick an instance by index
    wire [31:0] hi_w;
    wire [31:0] lo_w;
    wire [31:0] hh_w;
    wire [31:0] lh_w;
    wire [1:0] hen_w;
    wire [1:0] len_w;
    wire [1:0] htrip_w;
    wire [1:0] ltrip_w;

    reg [15:0] get_val;
    reg [7:0] get_st;
    reg settable;

    // attribute read mux and settable flags
    always @* begin
        get_val = 16'h0000;
        get_st = `ST_SUCCESS;
        settable = 1'b0;
        case (obj)
            `OBJ_SENSOR: begin
                case (attr)
                    `AT_VALID: get_val = {15'h0000, valid};
                    `AT_VALUE: get_val = value_reg;
                    `AT_OVERRANGE: get_val = OVERRANGE;
                    `AT_UNDERRANGE: get_val = UNDERRANGE;
                    `AT_WARNING: get_val = warn_word;
                    `AT_ALARM: get_val = alarm_word;
                    `AT_STATUS_EXT: get_val = {8'h00, status_ext};
                    default: get_st = `ST_ATTR_UNSUP;
                endcase
            end
            `OBJ_TRIP_CLASS: begin
                case (attr)
                    `AT_REVISION: get_val = `TRIP_REVISION; // RULE15
                    `AT_MAX_INST: get_val = `TRIP_MAX_INST; // RULE15
                    default: get_st = `ST_ATTR_UNSUP;
                endcase
            end
            default: begin
                case (attr)
                    `AT_HIGH_LIMIT: begin
                        get_val = hi_w[16*inst_sel +: 16];
                        settable = 1'b1;
                    end
                    `AT_HIGH_EN: begin
                        get_val = {15'h0000, hen_w[inst_sel]};
                        settable = 1'b1;
                    end
                    `AT_LOW_LIMIT: begin
                        get_val = lo_w[16*inst_sel +: 16];
                        settable = 1'b1;
                    end
                    `AT_LOW_EN: begin
                        get_val = {15'h0000, len_w[inst_sel]};
                        settable = 1'b1;
                    end
                    `AT_HIGH_HYST: begin
                        get_val = hh_w[16*inst_sel +: 16];
                        settable = 1'b1;
                    end
                    `AT_LOW_HYST: begin
                        get_val = lh_w[16*inst_sel +: 16];
                        settable = 1'b1;
                    end
                    `AT_OUT_STATUS: get_val = {15'h0000, htrip_w[inst_sel] | ltrip_w[inst_sel]}; // RULE20
                    `AT_TRIP_STATUS: get_val = {14'h0000, htrip_w[inst_sel], ltrip_w[inst_sel]};
                    default: get_st = `ST_ATTR_UNSUP;
                endcase
            end
        endcase
    end

    // service outcome
    // a refused set moves no attribute, so a bad request changes only the response registers
    reg [7:0] svc_st;
    reg [15:0] svc_data;
    reg do_set;
    reg do_gain;
    reg do_zero;

    always @* begin
        svc_st = `ST_SVC_UNSUP;
        svc_data = 16'h0000;
        do_set = 1'b0;
        do_gain = 1'b0;
        do_zero = 1'b0;
        case (svc)
            `SVC_GET: begin
                svc_st = get_st; // RULE5
                svc_data = get_val;
            end
            `SVC_SET: begin
                if (get_st != `ST_SUCCESS) begin
                    svc_st = get_st;
                end else if (!settable) begin
                    svc_st = `ST_NOT_SETTABLE; // RULE25
                end else begin
                    svc_st = `ST_SUCCESS;
                    do_set = 1'b1; // RULE6
                end
            end
            `SVC_GAIN_ADJ: begin
                if (obj == `OBJ_SENSOR) begin
                    svc_st = `ST_SUCCESS; // RULE7 RULE12
                    do_gain = 1'b1;
                end
            end
            `SVC_ZERO_ADJ: begin
                if (obj == `OBJ_SENSOR) begin
                    svc_st = `ST_SUCCESS; // RULE8 RULE12
                    do_zero = 1'b1;
                end
            end
            default: svc_st = `ST_SVC_UNSUP;
        endcase
    end

    // ==========================================================
    // response, calibration pulses and value register
    // the sequence count tells software a fresh response from a stale one
    // start pulses last one cycle; a slower sensor side must hold them itself
    reg [7:0] rsp_st_reg;
    reg [7:0] rsp_seq_reg;
    reg [15:0] rsp_data_reg;
    reg gain_reg;
    reg zero_reg;
    assign o_gain_cal_start = gain_reg;
    assign o_zero_cal_start = zero_reg;

    always @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rsp_st_reg <= `ST_SUCCESS;
            rsp_seq_reg <= 8'h00;
            rsp_data_reg <= 16'h0000;
            cmd_data_reg <= 32'h00000000;
            gain_reg <= 1'b0;
            zero_reg <= 1'b0;
            value_reg <= 16'sh0000;
        end else begin
            gain_reg <= cmd_wr & do_gain;
            zero_reg <= cmd_wr & do_zero;
            if (fire & i_write & (i_address == `OFS_CMD_DATA)) begin
                cmd_data_reg <= i_writedata;
            end
            if (cmd_wr) begin
                rsp_st_reg <= svc_st;
                rsp_data_reg <= svc_data;
                rsp_seq_reg <= rsp_seq_reg + 8'h01;
            end
            // calibration wins over a sample in the same cycle; no other state moves
            if (cmd_wr & do_gain) begin
                value_reg <= GAIN_TARGET; // RULE9 RULE11
            end else if (cmd_wr & do_zero) begin
                value_reg <= 16'sh0000; // RULE10 RULE11
            end else if (i_sample) begin
                value_reg <= i_sensor_value;
            end
        end
    end

    // ==========================================================
    // trip point instances
    // both enables reset low, so no relay moves until software arms it
    genvar k;
    generate
        for (k = 0; k < 2; k = k + 1) begin : g_trip
            reg signed [15:0] hi_reg;
            reg signed [15:0] lo_reg;
            reg signed [15:0] hh_reg;
            reg signed [15:0] lh_reg;
            reg hen_reg;
            reg len_reg;
            reg htrip_reg;
            reg ltrip_reg;
            reg relay_reg;
            reg htrip_next;
            reg ltrip_next;
            // 17-bit sums so a limit near full scale cannot wrap
            // a negative hysteresis is accepted; the set test still has priority
            wire signed [16:0] in_x = {value_reg[15], value_reg};
            wire signed [16:0] hclr = {hi_reg[15], hi_reg} - {hh_reg[15], hh_reg};
            wire signed [16:0] lclr = {lo_reg[15], lo_reg} + {lh_reg[15], lh_reg};
            wire wr_me = cmd_wr & do_set & is_inst & (inst_sel == k);
            wire [15:0] wv = cmd_data_reg[15:0];

            // next trip state, shared by the trip flops and the relay flop so the
            // relay pin is a flip-flop output without an extra cycle of delay
            always @* begin
                htrip_next = htrip_reg;
                ltrip_next = ltrip_reg;
                if (!hen_reg) begin
                    htrip_next = 1'b0; // RULE24
                end else if (value_reg >= hi_reg) begin
                    htrip_next = 1'b1; // RULE16
                end else if (in_x < hclr) begin
                    htrip_next = 1'b0; // RULE22
                end
                if (!len_reg) begin
                    ltrip_next = 1'b0; // RULE24
                end else if (value_reg <= lo_reg) begin
                    ltrip_next = 1'b1; // RULE18
                end else if (in_x > lclr) begin
                    ltrip_next = 1'b0; // RULE21
                end
            end

            always @(posedge i_ref_clk or negedge i_arst_n) begin
                if (!i_arst_n) begin
                    hi_reg <= HIGH_DEF;
                    lo_reg <= LOW_DEF;
                    hh_reg <= HYST_DEF;
                    lh_reg <= HYST_DEF;
                    hen_reg <= 1'b0;
                    len_reg <= 1'b0;
                    htrip_reg <= 1'b0;
                    ltrip_reg <= 1'b0;
                    relay_reg <= 1'b0;
                end else begin
                    if (wr_me) begin
                        case (attr)
                            `AT_HIGH_LIMIT: hi_reg <= wv; // RULE16
                            `AT_HIGH_EN: hen_reg <= wv[0]; // RULE17
                            `AT_LOW_LIMIT: lo_reg <= wv; // RULE18
                            `AT_LOW_EN: len_reg <= wv[0]; // RULE19
                            `AT_HIGH_HYST: hh_reg <= wv;
                            `AT_LOW_HYST: lh_reg <= wv;
                            default: hi_reg <= hi_reg;
                        endcase
                    end
                    htrip_reg <= htrip_next;
                    ltrip_reg <= ltrip_next;
                    relay_reg <= htrip_next | ltrip_next; // RULE14 RULE24
                end
            end

            assign hi_w[16*k +: 16] = hi_reg;
            assign lo_w[16*k +: 16] = lo_reg;
            assign hh_w[16*k +: 16] = hh_reg;
            assign lh_w[16*k +: 16] = lh_reg;
            assign hen_w[k] = hen_reg;
            assign len_w[k] = len_reg;
            assign htrip_w[k] = htrip_reg;
            assign ltrip_w[k] = ltrip_reg;
            assign o_relay[k] = relay_reg;
        end
    endgenerate

    // ==========================================================
    // register read data, latched in the waiting cycle
    // unmapped offsets read zero and have no side effect
    always @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rdata_reg <= 32'h00000000;
        end else if (i_read & ~ack_reg) begin
            case (i_address)
                `OFS_CMD_DATA: rdata_reg <= cmd_data_reg;
                `OFS_RSP: rdata_reg <= {16'h0000, rsp_seq_reg, rsp_st_reg};
                `OFS_RSP_DATA: rdata_reg <= {16'h0000, rsp_data_reg};
                `OFS_SENSE: rdata_reg <= {6'h00, o_relay, value_reg, status_ext};
                `OFS_DIAG: rdata_reg <= {alarm_word, warn_word};
                default: rdata_reg <= 32'h00000000;
            endcase
        end
    end

endmodule // gauge_trip

// ### tb/gauge_trip_properties.sv
// checker for the gauge slave logic: service starts, status maps and relay causes
// assumes it is bound to gauge_trip and sees only its ports
`timescale 1ns/1ps
`include "gauge_regs.vh"

module gauge_trip_properties #(
    parameter signed [15:0] OVERRANGE = 16'sh7fff,
    parameter signed [15:0] UNDERRANGE = -16'sh7fff
) (
    input wire i_ref_clk,
    input wire i_arst_n,
    input wire [4:0] i_address,
    input wire i_read,
    input wire i_write,
    input wire [31:0] i_writedata,
    input wire [31:0] o_readdata,
    input wire o_waitrequest,
    input wire i_sample,
    input wire [15:0] i_sensor_value,
    input wire i_elec_warn,
    input wire i_elem_fail,
    input wire i_elec_fail,
    input wire o_gain_cal_start,
    input wire o_zero_cal_start,
    input wire [1:0] o_relay
);
    // ==========
    // accepted accesses
    wire cmd_acc = i_write && !o_waitrequest && i_address == `OFS_CMD;
    wire obj0 = i_writedata[17:16] == `OBJ_SENSOR;
    wire gain_acc = cmd_acc && obj0 && i_writedata[7:0] == `SVC_GAIN_ADJ;
    wire zero_acc = cmd_acc && obj0 && i_writedata[7:0] == `SVC_ZERO_ADJ;
    wire rd_diag = i_read && !o_waitrequest && i_address == `OFS_DIAG;
    wire rd_sense = i_read && !o_waitrequest && i_address == `OFS_SENSE;
    wire signed [15:0] rd_val = o_readdata[23:8];

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_arst_n);

    // ==========
    // properties
    a_gain_start: assert property (gain_acc |=> o_gain_cal_start)
        else $error("gain adjust gave no start pulse");
    a_zero_start: assert property (zero_acc |=> o_zero_cal_start)
        else $error("zero adjust gave no start pulse");
    a_gain_cause: assert property (o_gain_cal_start |-> $past(gain_acc))
        else $error("gain pulse without request");
    a_zero_cause: assert property (o_zero_cal_start |-> $past(zero_acc))
        else $error("zero pulse without request");
    a_diag_map: assert property (rd_diag && $stable(i_elec_warn) && $stable(i_elem_fail) && $stable(i_elec_fail)
        |-> o_readdata == {6'h0, i_elec_fail, 8'h0, i_elem_fail, 6'h0, i_elec_warn, 9'h0})
        else $error("warning or alarm word wrong");
    a_ext_zero: assert property (rd_sense |-> o_readdata[7:3] == 5'h0 && o_readdata[31:26] == 6'h0)
        else $error("unused status bits set");
    a_invalid_map: assert property (rd_sense |-> o_readdata[0] == (rd_val > OVERRANGE || rd_val < UNDERRANGE))
        else $error("invalid bit disagrees with value");
    a_range_bits: assert property (rd_sense |-> o_readdata[2:1] == {rd_val < UNDERRANGE, rd_val > OVERRANGE})
        else $error("range bits disagree with value");
    a_relay_cause: assert property ($changed(o_relay) |-> $past(i_sample) || $past(i_sample, 2)
        || $past(i_write, 2) || $past(i_write, 3))
        else $error("relay moved without new value or setting");
    a_relay_sense: assert property (rd_sense && $stable(o_relay) |-> o_readdata[25:24] == o_relay)
        else $error("relay bits in status read wrong");

    c_gain: cover property (gain_acc);
    c_zero: cover property (zero_acc);
    c_invalid: cover property (rd_sense && o_readdata[0]);
endmodule // gauge_trip_properties

bind gauge_trip gauge_trip_properties #(.OVERRANGE(OVERRANGE), .UNDERRANGE(UNDERRANGE)) u_props (
    .i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_address(i_address), .i_read(i_read),
    .i_write(i_write), .i_writedata(i_writedata), .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
    .i_sample(i_sample), .i_sensor_value(i_sensor_value), .i_elec_warn(i_elec_warn),
    .i_elem_fail(i_elem_fail), .i_elec_fail(i_elec_fail), .o_gain_cal_start(o_gain_cal_start),
    .o_zero_cal_start(o_zero_cal_start), .o_relay(o_relay));

// ### tb/gauge_trip_tb_top.sv
// self-checking bench for gauge_trip with a behavioural trip model
// assumes the default parameters of the design and the master model in svc_master
`timescale 1ns/1ps
`include "gauge_regs.vh"

module gauge_trip_tb_top;
    logic i_ref_clk = 0, i_arst_n = 0, i_sample = 0, i_elec_warn = 0, i_elem_fail = 0, i_elec_fail = 0;
    logic [15:0] i_sensor_value = 16'h0;
    logic [31:0] rsp, rdat;
    wire [4:0] i_address;
    wire i_read, i_write, o_waitrequest, o_gain_cal_start, o_zero_cal_start;
    wire [31:0] i_writedata, o_readdata;
    wire [1:0] o_relay;
    int miscompares = 0, samples_checked = 0, gain_seen = 0, zero_seen = 0, seq = 0, val = 0;
    int hi[2] = '{32767, 32767}, hh[2] = '{16, 16}, lh[2] = '{16, 16};
    int lo[2], hen[2], len[2], htr[2], ltr[2], pv[4];
    int at[4] = '{3, 5, 18, 19};

    always #25 i_ref_clk = ~i_ref_clk;
    always @(negedge i_ref_clk) begin
        gain_seen += o_gain_cal_start;
        zero_seen += o_zero_cal_start;
    end

    gauge_trip dut (.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_address(i_address), .i_read(i_read),
        .i_write(i_write), .i_writedata(i_writedata), .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
        .i_sample(i_sample), .i_sensor_value(i_sensor_value), .i_elec_warn(i_elec_warn),
        .i_elem_fail(i_elem_fail), .i_elec_fail(i_elec_fail), .o_gain_cal_start(o_gain_cal_start),
        .o_zero_cal_start(o_zero_cal_start), .o_relay(o_relay));
    svc_master mst (.i_ref_clk(i_ref_clk), .i_waitrequest(o_waitrequest), .i_readdata(o_readdata),
        .o_address(i_address), .o_read(i_read), .o_write(i_write), .o_writedata(i_writedata));

    // ==========
    // checking and model
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic upd;
        for (int k = 0; k < 2; k++) begin
            htr[k] = hen[k] && (htr[k] ? val >= hi[k] - hh[k] : val >= hi[k]);
            ltr[k] = len[k] && (ltr[k] ? val <= lo[k] + lh[k] : val <= lo[k]);
        end
    endtask

    task automatic svc(input int code, attr, obj, data, st, dat);
        mst.service(code[7:0], attr[7:0], obj[1:0], data[15:0], rsp, rdat);
        seq++;
        check("response", rsp, {16'h0, seq[7:0], st[7:0]});
        check("response data", rdat, dat & 32'hffff);
    endtask

    task automatic chk_sense;
        mst.access(1'b0, `OFS_SENSE, 32'h0, rdat);
        check("sense", rdat, {6'h0, htr[1] || ltr[1], htr[0] || ltr[0], val[15:0], 5'h0,
            val < -32767, val > 32767, val < -32767 || val > 32767});
        check("relay pins", o_relay, {htr[1] || ltr[1], htr[0] || ltr[0]});
    endtask

    // ==========
    // tests
    initial begin
        void'($urandom(42));
        repeat (8) @(posedge i_ref_clk);
        i_arst_n <= 1'b1;
        chk_sense();
        for (int i = 0; i < 8; i++) begin
            @(posedge i_ref_clk);
            {i_elec_warn, i_elem_fail, i_elec_fail} <= i[2:0];
            @(posedge i_ref_clk);
            mst.access(1'b0, `OFS_DIAG, 32'h0, rdat);
            check("diag", rdat, {6'h0, i[0], 8'h0, i[1], 6'h0, i[2], 9'h0});
        end
        mst.access(1'b1, 5'h18, 32'hffff_ffff, rdat);
        mst.access(1'b0, 5'h18, 32'h0, rdat);
        check("unmapped", rdat, 32'h0);
        $display("diag test done");
        svc(`SVC_GET, `AT_REVISION, 1, 0, 0, 1);
        svc(`SVC_GET, `AT_MAX_INST, 1, 0, 0, 2);
        svc(`SVC_SET, `AT_REVISION, 1, 7, `ST_NOT_SETTABLE, 0);
        svc(`SVC_GET, `AT_REVISION, 1, 0, 0, 1);
        svc(`SVC_SET, `AT_OUT_STATUS, 2, 1, `ST_NOT_SETTABLE, 0);
        svc(`SVC_SET, `AT_VALUE, 0, 5, `ST_NOT_SETTABLE, 0);
        svc(`SVC_GET, 8'h63, 2, 0, `ST_ATTR_UNSUP, 0);
        svc(8'h55, `AT_VALUE, 0, 0, `ST_SVC_UNSUP, 0);
        svc(`SVC_GAIN_ADJ, 0, 2, 0, `ST_SVC_UNSUP, 0);
        for (int k = 0; k < 2; k++) begin
            hi[k] = $urandom_range(150, 60);
            lo[k] = -int'($urandom_range(150, 60));
            hh[k] = $urandom_range(40, 0);
            lh[k] = $urandom_range(40, 0);
            pv = '{hi[k], lo[k], hh[k], lh[k]};
            foreach (at[j]) svc(`SVC_SET, at[j], 2 + k, pv[j], 0, 0);
            foreach (at[j]) svc(`SVC_GET, at[j], 2 + k, 0, 0, pv[j]);
        end
        $display("service test done");
        for (int n = 0; n < 60; n++) begin
            if (n % 6 == 0) for (int k = 0; k < 2; k++) begin
                hen[k] = $urandom_range(1, 0);
                len[k] = $urandom_range(1, 0);
                svc(`SVC_SET, `AT_HIGH_EN, 2 + k, hen[k], 0, 0);
                svc(`SVC_SET, `AT_LOW_EN, 2 + k, len[k], 0, 0);
                upd();
            end
            val = (n == 30) ? -32768 : int'($urandom_range(300, 0)) - 150;
            @(posedge i_ref_clk);
            i_sensor_value <= val[15:0];
            i_sample <= 1'b1;
            @(posedge i_ref_clk);
            i_sample <= 1'b0;
            upd();
            chk_sense();
            svc(`SVC_GET, `AT_OUT_STATUS, 3, 0, 0, htr[1] || ltr[1]);
            svc(`SVC_GET, `AT_TRIP_STATUS, 2, 0, 0, 2 * htr[0] + ltr[0]);
        end
        $display("trip test done");
        svc(`SVC_GAIN_ADJ, 0, 0, 0, 0, 0);
        val = 16000;
        upd();
        chk_sense();
        check("gain pulses", gain_seen, 1);
        svc(`SVC_ZERO_ADJ, 0, 0, 0, 0, 0);
        val = 0;
        upd();
        chk_sense();
        check("zero pulses", zero_seen, 1);
        svc(`SVC_GET, `AT_VALUE, 0, 0, 0, 0);
        svc(`SVC_GET, `AT_HIGH_EN, 2, 0, 0, hen[0]);
        $display("calibration test done");
        close_out();
    end

    initial begin
        #2000000;
        miscompares++;
        close_out();
    end
endmodule // gauge_trip_tb_top

// ### tb/svc_master.sv
// far-side master model: issues service requests as avalon-mm word accesses
// assumes the slave answers through waitrequest on i_ref_clk
`timescale 1ns/1ps
`include "gauge_regs.vh"

module svc_master (
    input wire i_ref_clk,
    input wire i_waitrequest,
    input wire [31:0] i_readdata,
    output logic [4:0] o_address = 5'h1f,
    output logic o_read = 1'b0,
    output logic o_write = 1'b0,
    output logic [31:0] o_writedata = 32'h0
);
    // ==========
    // single access, held until waitrequest is seen low
    task automatic access(input logic wr, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
        logic w;
        @(posedge i_ref_clk);
        o_address <= a;
        o_writedata <= d;
        o_read <= !wr;
        o_write <= wr;
        // waitrequest and read data are taken at the rising edge that ends the access
        do begin
            @(posedge i_ref_clk);
            w = i_waitrequest;
            q = i_readdata;
        end while (w !== 1'b0);
        o_read <= 1'b0;
        o_write <= 1'b0;
        o_address <= ~a;
        o_writedata <= ~d;
    endtask

    // ==========
    // one service: data word, command word (never with a target), then both response words
    task automatic service(input logic [7:0] code, input logic [7:0] attr, input logic [1:0] obj,
                           input logic [15:0] data, output logic [31:0] rsp, output logic [31:0] rdat);
        logic [31:0] q;
        access(1'b1, `OFS_CMD_DATA, {16'h0, data}, q);
        access(1'b1, `OFS_CMD, {7'h0, 1'b0, 6'h0, obj, attr, code}, q);
        access(1'b0, `OFS_RSP, 32'h0, rsp);
        access(1'b0, `OFS_RSP_DATA, 32'h0, rdat);
    endtask
endmodule // svc_master
